// *** verilog/pcs_pkg.sv ***
// shared constants and types of the program counter sequencer
// assumes one 100 MHz system clock; one system clock period per clk period
package pcs_pkg;

  localparam int PC_WIDTH    = 12;       // counter width, 4096 words
  localparam int WORD_WIDTH  = 15;       // program memory word width
  localparam int PAGE_WIDTH  = 8;        // short jump page, 256 words
  localparam int PHASES      = 4;        // system clocks per instruction cycle
  localparam int STACK_DEPTH = 8;        // return stack levels
  localparam int IRQ_COUNT   = 6;        // vectored interrupt sources

  // register port offsets
  localparam logic [7:0] REG_PTR_LOW     = 8'h06; // instr_pointer_low
  localparam logic [7:0] REG_LOOKUP_PTR  = 8'h07; // lookup_pointer
  localparam logic [7:0] REG_TABLE_HIGH  = 8'h08; // upper table bits, read only
  localparam logic [7:0] REG_PTR_HIGH    = 8'h20; // counter bits 11..8, read only

  // reset values and fixed addresses
  localparam logic [11:0] RESET_VECTOR   = 12'h000;
  localparam logic [11:0] IRQ_BASE       = 12'h004; // first interrupt vector
  localparam logic [11:0] IRQ_STRIDE     = 12'h004; // spacing of vectors
  localparam logic [3:0]  LAST_PAGE      = 4'hF;    // page of last-page table reads
  localparam logic [7:0]  LOOKUP_RESET   = 8'h00;

  // start-up timer, in system clock periods, then in clk cycles
  localparam int SST_TSYS     = 1024;
  localparam int CLK_PER_TSYS = 1;
  localparam int SST_CYCLES   = SST_TSYS * CLK_PER_TSYS;

  // operation reported by the decoder for the executing instruction
  typedef enum logic [2:0] {
    OP_NEXT,
    OP_SKIP,
    OP_JUMP,
    OP_CALL,
    OP_RETURN,
    OP_TABLE_CUR,
    OP_TABLE_LAST,
    OP_HALT
  } pcs_op_type;

  typedef enum logic [1:0] {
    RUN_START,
    RUN_EXEC,
    RUN_HALT
  } pcs_run_type;

endpackage

// *** verilog/pcs_return_stack.sv ***
// eight level return stack for the sequencer, not visible to software
// assumes push and pop are never asserted together
`timescale 1ns/1ns
`default_nettype none
module pcs_return_stack #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,      // system clock
  input  wire logic             rstn,     // async reset, active low
  input  wire logic             push,     // store pushData
  input  wire logic             pop,      // drop top entry
  input  wire logic [WIDTH-1:0] pushData, // return address
  output logic      [WIDTH-1:0] top,      // top entry
  output logic                  full      // all levels used
);
  import pcs_pkg::*;

  localparam int PW = $clog2(DEPTH);

  // elaboration check: pointer wrap needs a power-of-two depth
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("pcs_return_stack: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] entry;
    logic [PW-1:0]               ptr;
    logic [PW:0]                 count;
  } pcs_stack_type;

  pcs_stack_type st;
  pcs_stack_type next_st;

  // circular storage: a push when full overwrites the oldest level
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.entry[st.ptr] = pushData;
      next_st.ptr           = st.ptr + PW'(1);
      if (st.count != (PW+1)'(DEPTH))
        next_st.count = st.count + (PW+1)'(1);
    end else if (pop) begin
      next_st.ptr = st.ptr - PW'(1);
      if (st.count != '0)
        next_st.count = st.count - (PW+1)'(1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign top  = st.entry[st.ptr - PW'(1)];
  assign full = (st.count == (PW+1)'(DEPTH));
endmodule
`default_nettype wire

// *** verilog/pcs_sequencer.sv ***
// instruction sequencer: phase generator, fetch/execute pipeline, 12-bit counter
// assumes a combinational decoder answers op/skip for instrWord in the same cycle
// assumes irqReq bits are already enabled and flagged by interrupt control logic
//
// Functional notes
// - four system clocks form one instruction cycle, phases 0 to 3
// - fetch in one instruction cycle, execute it in the next, overlapped
// - any counter change costs a second cycle; prefetched word becomes dummy
// - counter is 12 bits, reaching 4096 program words
// - counter advances by one after each fetched word
// - true skip discards the prefetched word; counter ends two further on
// - reset clears the counter, execution starts at word zero
// - first external request loads vector 004H when stack not full
// - vectors 008H, 00CH, 010H, 014H, 018H for the other five sources
// - low byte write replaces bits 7..0, keeps 11..8, short jump
// - jump and call load all twelve bits from the instruction
// - return loads all twelve bits from the top stack entry
// - program memory 4096 x 15, addressed by counter or lookup pointer
// - after reset or wake from halt wait 1024 system clocks
// - eight level hidden return stack, pushed on calls and interrupts
// - stack full holds interrupt acknowledge until a return frees a level
`timescale 1ns/1ns
`default_nettype none
module pcs_sequencer #(
  parameter int SST_COUNT = pcs_pkg::SST_CYCLES
) (
  input  wire logic                              clk,          // system clock
  input  wire logic                              rstn,         // async reset
  input  wire logic [pcs_pkg::WORD_WIDTH-1:0]    memData,      // program word
  input  wire pcs_pkg::pcs_op_type               op,           // decoded op
  input  wire logic                              skipTrue,     // skip taken
  input  wire logic [pcs_pkg::IRQ_COUNT-1:0]     irqReq,       // enabled requests
  input  wire logic                              wake,         // halt wake event
  input  wire logic [7:0]                        regAddr,      // register address
  input  wire logic [7:0]                        regWdata,     // write data
  input  wire logic                              regWr,        // write strobe
  input  wire logic                              regRd,        // read strobe
  output logic      [7:0]                        regRdata,     // read data
  output logic      [pcs_pkg::PC_WIDTH-1:0]      memAddr,      // memory address
  output logic      [pcs_pkg::WORD_WIDTH-1:0]    instrWord,    // executing word
  output logic                                   instrValid,   // not a dummy
  output logic      [1:0]                        cyclePhase,   // clock phase
  output logic                                   cycleEnd,     // last phase
  output logic      [pcs_pkg::PC_WIDTH-1:0]      instrPointer, // counter
  output logic      [pcs_pkg::WORD_WIDTH-1:0]    tableWord,    // table result
  output logic      [pcs_pkg::IRQ_COUNT-1:0]     irqAck,       // ack pulse
  output logic                                   running       // executing
);
  import pcs_pkg::*;

  localparam int CW = $clog2(SST_COUNT + 1);

  // elaboration check: the start-up timer needs at least one edge
  if (SST_COUNT < 1) begin : g_bad_count
    $error("pcs_sequencer: SST_COUNT must be at least 1");
  end

  typedef struct packed {
    pcs_run_type           run;
    logic [CW-1:0]         startCnt;
    logic [1:0]            phase;
    logic                  cycleEnd;
    logic [PC_WIDTH-1:0]   pc;
    logic [PC_WIDTH-1:0]   memAddr;
    logic [WORD_WIDTH-1:0] instr;
    logic                  instrValid;
    logic                  tableDummy;
    logic [WORD_WIDTH-1:0] tableWord;
    logic [7:0]            lookupPointer;
    logic                  lowPend;
    logic [7:0]            lowData;
    logic [7:0]            rdData;
    logic [IRQ_COUNT-1:0]  irqAck;
    logic                  running;
  } pcs_state_type;

  pcs_state_type st;
  pcs_state_type next_st;

  logic                stackPush;
  logic                stackPop;
  logic [PC_WIDTH-1:0] stackPushData;
  logic [PC_WIDTH-1:0] stackTop;
  logic                stackFull;

  // vector of interrupt source idx
  function automatic logic [PC_WIDTH-1:0] irqVector(input int idx);
    irqVector = IRQ_BASE + PC_WIDTH'(idx) * IRQ_STRIDE;
  endfunction

  // program word of a table read in page pg
  function automatic logic [PC_WIDTH-1:0] tableAddr(input logic [3:0] pg,
                                                    input logic [7:0] ptr);
    tableAddr = {pg, ptr};
  endfunction

  // return stack, hidden from software
  pcs_return_stack #(
    .WIDTH (PC_WIDTH),
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clk      (clk),
    .rstn     (rstn),
    .push     (stackPush),
    .pop      (stackPop),
    .pushData (stackPushData),
    .top      (stackTop),
    .full     (stackFull)
  );

  // sequencing decisions taken at the end of each instruction cycle
  always_comb begin
    logic                  lastPhase;
    logic                  flowChange;
    logic                  irqPending;
    int                    irqIdx;
    logic [PC_WIDTH-1:0]   pcNext;
    next_st       = st;
    stackPush     = 1'b0;
    stackPop      = 1'b0;
    stackPushData = st.pc;
    lastPhase     = (st.phase == 2'(PHASES - 1));
    flowChange    = 1'b0;
    irqPending    = 1'b0;
    irqIdx        = 0;
    pcNext        = st.pc + PC_WIDTH'(1);
    next_st.irqAck = '0;
    next_st.rdData = 8'h00;

    // fixed priority pick among pending requests
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (irqReq[i]) begin
        irqPending = 1'b1;
        irqIdx     = i;
      end
    end

    // register port: reads answer in the next cycle only
    if (regRd) begin
      case (regAddr)
        REG_PTR_LOW:    next_st.rdData = st.pc[7:0];
        REG_PTR_HIGH:   next_st.rdData = {4'h0, st.pc[11:8]};
        REG_LOOKUP_PTR: next_st.rdData = st.lookupPointer;
        REG_TABLE_HIGH: next_st.rdData = {1'b0, st.tableWord[14:8]};
        default:        next_st.rdData = 8'h00;
      endcase
    end
    if (regWr && regAddr == REG_LOOKUP_PTR) begin
      next_st.lookupPointer = regWdata;
    end
    // low byte write is held until the cycle boundary
    if (regWr && regAddr == REG_PTR_LOW) begin
      next_st.lowPend = 1'b1;
      next_st.lowData = regWdata;
    end

    case (st.run)
      RUN_START: begin
        // start-up timer, phases held still
        next_st.phase    = 2'd0;
        next_st.cycleEnd = 1'b0;
        if (st.startCnt == CW'(SST_COUNT - 1)) begin
          next_st.run      = RUN_EXEC;
          next_st.startCnt = '0;
        end else begin
          next_st.startCnt = st.startCnt + CW'(1);
        end
      end

      RUN_EXEC: begin
        next_st.phase    = st.phase + 2'd1;
        next_st.cycleEnd = (st.phase == 2'(PHASES - 2));
        if (lastPhase) begin
          // fetched word moves to execute, counter moves on
          next_st.instr      = memData;
          next_st.instrValid = 1'b1;
          next_st.tableDummy = 1'b0;
          if (st.tableDummy) begin
            // dummy cycle of a table read: capture word, counter held
            next_st.tableWord  = memData;
            next_st.instrValid = 1'b0;
            pcNext             = st.pc;
          end else if (st.lowPend) begin
            pcNext     = {st.pc[PC_WIDTH-1:PAGE_WIDTH], st.lowData};
            flowChange = 1'b1;
          end else if (st.instrValid) begin
            case (op)
              OP_SKIP: begin
                if (skipTrue) begin
                  pcNext     = st.pc + PC_WIDTH'(1);
                  flowChange = 1'b1;
                end
              end
              OP_JUMP: begin
                pcNext     = st.instr[PC_WIDTH-1:0];
                flowChange = 1'b1;
              end
              OP_CALL: begin
                stackPush  = 1'b1;
                pcNext     = st.instr[PC_WIDTH-1:0];
                flowChange = 1'b1;
              end
              OP_RETURN: begin
                stackPop   = 1'b1;
                pcNext     = stackTop;
                flowChange = 1'b1;
              end
              OP_TABLE_CUR: begin
                next_st.tableDummy = 1'b1;
                pcNext             = st.pc;
                flowChange         = 1'b1;
              end
              OP_TABLE_LAST: begin
                next_st.tableDummy = 1'b1;
                pcNext             = st.pc;
                flowChange         = 1'b1;
              end
              OP_HALT: begin
                next_st.run = RUN_HALT;
                pcNext      = st.pc;
                flowChange  = 1'b1;
              end
              default: begin
                pcNext = st.pc + PC_WIDTH'(1);
              end
            endcase
          end
          // interrupt only between ordinary instructions, stack not full
          if (!flowChange && !st.tableDummy && irqPending && !stackFull) begin
            stackPush              = 1'b1;
            stackPushData          = st.pc;
            pcNext                 = irqVector(irqIdx);
            flowChange             = 1'b1;
            next_st.irqAck[irqIdx] = 1'b1;
          end
          if (flowChange) begin
            next_st.instrValid = 1'b0;
          end
          if (!st.tableDummy) begin
            next_st.lowPend = regWr && regAddr == REG_PTR_LOW;
          end
          next_st.pc = pcNext;
          // table reads place the lookup word on the bus for the dummy
          if (next_st.tableDummy) begin
            next_st.memAddr = tableAddr(op == OP_TABLE_LAST ? LAST_PAGE
                                        : st.pc[11:8], st.lookupPointer);
          end else begin
            next_st.memAddr = pcNext;
          end
          if (next_st.run == RUN_HALT) begin
            next_st.phase    = 2'd0;
            next_st.cycleEnd = 1'b0;
          end
        end
      end

      RUN_HALT: begin
        // halted: wake restarts through the start-up timer
        next_st.phase      = 2'd0;
        next_st.cycleEnd   = 1'b0;
        next_st.instrValid = 1'b0;
        if (wake) begin
          next_st.run      = RUN_START;
          next_st.startCnt = '0;
        end
      end

      default: begin
        next_st.run = RUN_START;
      end
    endcase
    // running output kept in its own flip-flop
    next_st.running = (next_st.run == RUN_EXEC);
  end

  // state register, counter cleared to the reset vector
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st               <= '0;
      st.run           <= RUN_START;
      st.pc            <= RESET_VECTOR;
      st.memAddr       <= RESET_VECTOR;
      st.lookupPointer <= LOOKUP_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flip-flops
  assign regRdata     = st.rdData;
  assign memAddr      = st.memAddr;
  assign instrWord    = st.instr;
  assign instrValid   = st.instrValid;
  assign cyclePhase   = st.phase;
  assign cycleEnd     = st.cycleEnd;
  assign instrPointer = st.pc;
  assign tableWord    = st.tableWord;
  assign irqAck       = st.irqAck;
  assign running      = st.running;
endmodule
`default_nettype wire

// *** tb/pcs_seq_chk.sv ***
// assertions on the sequencer ports
// assumes one clock and an async active-low reset
`timescale 1ns/1ns
`default_nettype none
module pcs_seq_chk #(
  parameter int SST_COUNT = 8
) (
  input wire logic                clk,          // clock
  input wire logic                rstn,         // reset
  input wire pcs_pkg::pcs_op_type op,           // decoded op
  input wire logic                skipTrue,     // skip taken
  input wire logic [5:0]          irqReq,       // requests
  input wire logic [7:0]          regAddr,      // reg address
  input wire logic                regWr,        // write strobe
  input wire logic                regRd,        // read strobe
  input wire logic [7:0]          regRdata,     // read data
  input wire logic [11:0]         memAddr,      // fetch address
  input wire logic [14:0]         instrWord,    // executing word
  input wire logic                instrValid,   // not dummy
  input wire logic [1:0]          cyclePhase,   // phase
  input wire logic                cycleEnd,     // last phase
  input wire logic [11:0]         instrPointer, // counter
  input wire logic [5:0]          irqAck,       // ack pulse
  input wire logic                running       // executing
);
  import pcs_pkg::*;
  logic        wrPend; // low byte write not yet applied
  logic [10:0] cnt;    // edges since reset, saturating
  logic [11:0] vec;    // vector of the acked source
  // pending short jump and start-up count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend <= 1'b0;
      cnt    <= 11'h000;
    end else begin
      wrPend <= (regWr && regAddr == REG_PTR_LOW) || (wrPend && !cycleEnd);
      cnt    <= (cnt == 11'h7FF) ? cnt : cnt + 11'h001;
    end
  end
  // vector of the acked source
  always_comb begin
    vec = 12'h000;
    for (int i = 0; i < 6; i++) begin
      if (irqAck[i]) begin
        vec = IRQ_BASE + 12'(4 * i);
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_exec(pcs_op_type o);
    cycleEnd && instrValid && op == o;
  endsequence
  sequence s_quiet;
    irqReq == 6'h00 && !wrPend;
  endsequence
  property p_phase;
    running && $past(running) |-> cyclePhase == $past(cyclePhase) + 2'h1;
  endproperty
  a_phase: assert property (p_phase) else $error("phase did not advance");
  property p_end;
    running |-> cycleEnd == (cyclePhase == 2'h3);
  endproperty
  a_end: assert property (p_end) else $error("cycle end off phase three");
  property p_hold;
    running && $past(running) && !$past(cycleEnd) |-> $stable(instrWord) && $stable(instrPointer);
  endproperty
  a_hold: assert property (p_hold) else $error("pipeline moved inside a cycle");
  property p_next;
    s_exec(OP_NEXT) ##0 s_quiet |=> instrPointer == $past(instrPointer) + 12'h001 && instrValid;
  endproperty
  a_next: assert property (p_next) else $error("counter did not step by one");
  property p_skip;
    s_exec(OP_SKIP) ##0 s_quiet |=> instrPointer == $past(instrPointer) + 12'h001
      && instrValid == !$past(skipTrue);
  endproperty
  a_skip: assert property (p_skip) else $error("skip handled wrongly");
  property p_jump;
    (s_exec(OP_JUMP) or s_exec(OP_CALL)) ##0 !wrPend |=> instrPointer == 12'($past(instrWord))
      && memAddr == instrPointer && !instrValid;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or dummy wrong");
  property p_table;
    (s_exec(OP_TABLE_CUR) or s_exec(OP_TABLE_LAST)) ##0 s_quiet |=> !instrValid
      && instrPointer == $past(instrPointer)
      && memAddr[11:8] == ($past(op) == OP_TABLE_LAST ? LAST_PAGE : $past(instrPointer[11:8]));
  endproperty
  a_table: assert property (p_table) else $error("table read address wrong");
  property p_ack;
    irqAck != 6'h00 |-> $past(cycleEnd) && instrPointer == vec && !instrValid
      && irqAck == ($past(irqReq) & (~$past(irqReq) + 6'h01));
  endproperty
  a_ack: assert property (p_ack) else $error("interrupt ack or vector wrong");
  property p_rdlow;
    regRd && regAddr == REG_PTR_LOW && !wrPend |=> regRdata == 8'($past(instrPointer));
  endproperty
  a_rdlow: assert property (p_rdlow) else $error("low byte read wrong");
  property p_rdhigh;
    regRd && regAddr == REG_PTR_HIGH |=> regRdata == 8'($past(instrPointer) >> 8);
  endproperty
  a_rdhigh: assert property (p_rdhigh) else $error("high bits read wrong");
  property p_start;
    $rose(running) && cnt < 11'(SST_COUNT + 4) |-> memAddr == RESET_VECTOR
      && (cnt == 11'(SST_COUNT) || cnt == 11'(SST_COUNT + 1));
  endproperty
  a_start: assert property (p_start) else $error("start-up wait wrong");
endmodule
bind pcs_sequencer pcs_seq_chk #(.SST_COUNT(SST_COUNT)) u_chk (
  .clk, .rstn, .op, .skipTrue, .irqReq, .regAddr, .regWr, .regRd, .regRdata,
  .memAddr, .instrWord, .instrValid, .cyclePhase, .cycleEnd, .instrPointer,
  .irqAck, .running);
`default_nettype wire

// *** tb/pcs_mem_model.sv ***
// program store and instruction decoder beside the sequencer
// assumes the bench fills mem before reset is released
`timescale 1ns/1ns
`default_nettype none
module pcs_mem_model (
  input  wire logic [11:0]         memAddr,    // fetch address
  input  wire logic [14:0]         instrWord,  // executing word
  input  wire logic                instrValid, // not dummy
  output logic      [14:0]         memData,    // fetched word
  output var pcs_pkg::pcs_op_type  op,         // decoded op
  output logic                     skipTrue    // skip condition
);
  import pcs_pkg::*;
  logic [14:0] mem [4096]; // 4096 words of 15 bits
  // combinational read; top bits name the operation
  assign memData  = mem[memAddr];
  assign op       = instrValid ? pcs_op_type'(instrWord[14:12]) : OP_NEXT;
  assign skipTrue = instrWord[0];
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// bench for pcs_sequencer: program flow, interrupts, register port
// assumes pcs_mem_model as program store and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pcs_pkg::*;
  localparam int SST = 8; // short start-up count
  logic        clk      = 1'b0;
  logic        rstn     = 1'b0;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic        wake     = 1'b0;
  logic        rdLast   = 1'b0;
  logic [7:0]  regAddr  = 8'h00;
  logic [7:0]  regWdata = 8'h00;
  logic [5:0]  irqReq   = 6'h00;
  logic [7:0]  regRdata;
  logic [14:0] memData, instrWord, tableWord;
  logic [11:0] memAddr, instrPointer;
  logic [5:0]  irqAck;
  logic [1:0]  cyclePhase;
  logic        instrValid, cycleEnd, running, skipTrue;
  pcs_op_type  op;
  int          nMismatch = 0;
  int          checks    = 0;
  logic [15:0] traceQ[$];
  logic [15:0] expQ[$];
  // 100 MHz clock
  always #5 clk = ~clk;
  pcs_sequencer #(.SST_COUNT(SST)) u_dut (.clk, .rstn, .memData, .op, .skipTrue,
    .irqReq, .wake, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .memAddr, .instrWord, .instrValid, .cyclePhase, .cycleEnd, .instrPointer,
    .tableWord, .irqAck, .running);
  pcs_mem_model u_mem (.memAddr, .instrWord, .instrValid, .memData, .op, .skipTrue);
  // compare and count
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // one-cycle register read, answer noted
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    expQ.push_back({8'h00, e});
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // executed words and read answers against the oldest note
  always @(negedge clk) begin
    if ((running & instrValid) === 1'b1 && cyclePhase === 2'h0 && traceQ.size() > 0) begin
      chk("instrWord", {1'b0, instrWord}, traceQ.pop_front());
    end
    if (rdLast) begin
      chk("regRdata", {8'h00, regRdata}, expQ.pop_front());
    end
    rdLast = regRd;
  end
  // hang guard, the tests need about 250 cycles
  initial begin
    #100000;
    nMismatch++;
    close_out();
  end
  // main sequence
  initial begin
    logic [11:0] tr [11];
    logic [5:0]  m;
    logic [7:0]  d;
    logic [3:0]  hi;
    int          idx;
    tr = '{12'h000, 12'h100, 12'h101, 12'h103, 12'h104, 12'h200, 12'h201, 12'h105, 12'h106,
           12'h107, 12'h108};
    for (int a = 0; a < 4096; a++) begin
      u_mem.mem[a] = {OP_NEXT, 12'(a)};
    end
    u_mem.mem[0]      = {OP_JUMP, 12'h100};
    u_mem.mem[12'h101] = {OP_SKIP, 12'h001}; // condition true
    u_mem.mem[12'h103] = {OP_SKIP, 12'h000}; // condition false
    u_mem.mem[12'h104] = {OP_CALL, 12'h200};
    u_mem.mem[12'h201] = {OP_RETURN, 12'h000};
    u_mem.mem[12'h106] = {OP_TABLE_CUR, 12'h000};  // current page table read
    u_mem.mem[12'h107] = {OP_TABLE_LAST, 12'h000}; // last page table read
    u_mem.mem[12'h108] = {OP_HALT, 12'h000};
    u_mem.mem[12'hF00] = 15'h4BC6;                 // last-page table word
    for (int i = 0; i < 6; i++) begin
      u_mem.mem[4 + 4 * i] = {OP_RETURN, 12'h000};
    end
    foreach (tr[i]) traceQ.push_back({1'b0, u_mem.mem[tr[i]]});
    void'($urandom(23165));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("running", running, 16'h0);
    chk("memAddr", memAddr, 16'h0);
    for (int i = 0; i < SST + 4 && running !== 1'b1; i++) @(negedge clk);
    chk("running", running, 16'h1);
    $display("test startup done");
    for (int i = 0; i < 200 && traceQ.size() > 0; i++) @(negedge clk);
    chk("trace", 16'(traceQ.size()), 16'h0);
    $display("test flow done");
    chk("tableWord", {1'b0, tableWord}, {1'b0, u_mem.mem[12'hF00]});
    for (int i = 0; i < 8 && running !== 1'b0; i++) @(negedge clk);
    chk("halt", running, 16'h0);
    @(posedge clk);
    wake <= 1'b1;
    traceQ.push_back({1'b0, u_mem.mem[12'h109]});
    @(posedge clk);
    wake <= 1'b0;
    repeat (SST) @(negedge clk);
    chk("startWait", running, 16'h0);
    for (int i = 0; i < 20 && traceQ.size() > 0; i++) @(negedge clk);
    chk("resume", 16'(traceQ.size()), 16'h0);
    $display("test halt done");
    for (int k = 0; k < 8; k++) begin
      m = (k < 6) ? 6'(1 << k) : 6'($urandom_range(63, 1));
      idx = 0;
      while (!m[idx]) idx++;
      @(posedge clk);
      irqReq <= m;
      for (int i = 0; i < 40 && irqAck === 6'h00; i++) @(negedge clk);
      chk("irqAck", irqAck, 16'(6'h01 << idx));
      chk("vector", instrPointer, 16'(IRQ_BASE + 12'(4 * idx)));
      traceQ.push_back({1'b0, u_mem.mem[4 + 4 * idx]});
      @(posedge clk);
      irqReq <= 6'h00;
      for (int i = 0; i < 40 && traceQ.size() > 0; i++) @(negedge clk);
      chk("isr", 16'(traceQ.size()), 16'h0);
      repeat (8) @(negedge clk);
    end
    $display("test interrupts done");
    rd(REG_TABLE_HIGH, {1'b0, u_mem.mem[12'hF00][14:8]});
    @(negedge clk);
    while (cyclePhase !== 2'h0) @(negedge clk);
    hi = instrPointer[11:8];
    d = 8'($urandom);
    wr(REG_PTR_LOW, d);
    do @(negedge clk); while (cycleEnd !== 1'b1);
    @(negedge clk);
    chk("shortJump", instrPointer, {4'h0, hi, d});
    chk("dummy", instrValid, 16'h0);
    rd(REG_PTR_LOW, d);
    rd(REG_PTR_HIGH, {4'h0, hi});
    wr(REG_LOOKUP_PTR, d ^ 8'hA5);
    rd(REG_LOOKUP_PTR, d ^ 8'hA5);
    rd(8'h55, 8'h00);
    repeat (2) @(negedge clk);
    chk("reads", 16'(expQ.size()), 16'h0);
    $display("test registers done");
    close_out();
  end
endmodule
`default_nettype wire
